// ### verilog/dfcw_core.v
/*
 * fault merge, gain/offset calibration, clear, serial frames with crc-8,
 * status echo and watchdog for a four-channel dac, plus an apb register port.
 * assumes: analog comparators and pins are asynchronous; apb on clk.
 */
// Decided for this implementation: the address map and the APB interface to the registers.
// How it works
// - any fault pulls shared open-drain fault low
// - low headroom flag counts as current fault
// - short limit selectable; short sets vout fault
// - unipolar mode: low output reports short
// - over-temperature sets fault and status bit
// - code = d*(gain+1)/4096 + offset - 2048
// - 12-bit gain all ones, offset mid-scale
// - gain/offset writes wait for next data
// - one multiplier serves channels in turn
// - echo on: status shifted out each frame
// - echo off at reset; blocks other readback
// - clear rising edge loads enabled channels' code
// - channels without clear enable keep output
// - cleared channels hold until new write
// - 32-bit frame checked; bad one faults
// - status read clears packet error bit
// - missing keep-alive raises watchdog alert
// - main control sets enable and timeout
// - alert is push-pull, active high
// - per-channel bit selects external resistor
// - packet error marks last bad word
`include "dfcw_defines.vh"
`default_nettype none

module dfcw_core #(
	parameter [31:0] MS_CYCLES = `DFCW_CLK_MHZ * 1000
) (
	input wire clk,
	input wire rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire serialClk,
	input wire frameSelN,
	input wire serialDataIn,
	output reg serialDataOut,
	input wire clearIn,
	input wire [3:0] headroomLow,
	input wire [3:0] voutShort,
	input wire [3:0] voutLow,
	input wire unipolarMode,
	input wire overTemp,
	output reg faultOut,
	output reg faultOe,
	output reg alertOut,
	output reg [47:0] dacCode,
	output reg [3:0] extRsetSel,
	output reg [3:0] shortLimit8mA
);

localparam [17:0] MS_LAST = MS_CYCLES[17:0] - 18'h1;

// ----------------------------------------
// pin synchronisers and edges
// ----------------------------------------
wire [17:0] pinS;
dfcw_sync #(.W(18)) uSync (
	.clk(clk),
	.rst(rst),
	.d({serialClk, ~frameSelN, serialDataIn, clearIn, headroomLow, voutShort,
		voutLow, unipolarMode, overTemp}),
	.q(pinS)
);
wire sclkS = pinS[17];
// select kept inverted in the flops: their reset reads as idle, no false edge
wire selS = ~pinS[16];
wire sdinS = pinS[15];
wire clrS = pinS[14];
wire [3:0] headS = pinS[13:10];
wire [3:0] shortS = pinS[9:6];
wire [3:0] lowS = pinS[5:2];
wire uniS = pinS[1];
wire otS = pinS[0];

reg sclkD_reg;
reg selD_reg;
reg clrD_reg;
always @(posedge clk or posedge rst) begin
	if (rst) begin
		sclkD_reg <= 1'b0;
		selD_reg <= 1'b1;
		clrD_reg <= 1'b0;
	end else begin
		sclkD_reg <= sclkS;
		selD_reg <= selS;
		clrD_reg <= clrS;
	end
end
wire sclkRise = sclkS & ~sclkD_reg;
wire sclkFall = ~sclkS & sclkD_reg;
wire selFall = ~selS & selD_reg;
wire selRise = selS & ~selD_reg;
wire clrRise = clrS & ~clrD_reg;

// ----------------------------------------
// functions
// ----------------------------------------
function [7:0] crc8;
	input [23:0] w;
	integer k;
	reg [7:0] c;
	begin
		c = 8'h00;
		for (k = 23; k >= 0; k = k - 1) begin
			if (c[7] ^ w[k]) begin
				c = {c[6:0], 1'b0} ^ `DFCW_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc8 = c;
	end
endfunction

reg [11:0] dataArr [0:3];
reg [11:0] gainArr [0:3];
reg [11:0] offsArr [0:3];
reg [11:0] clrArr [0:3];
reg [2:0] chCtlArr [0:3];
reg [3:0] mainCtl_reg;
reg [15:0] statusWord;

function regValid;
	input [4:0] a;
	begin
		regValid = (a[4:2] <= `DFCW_GRP_CHCTL) || (a == `DFCW_IDX_MAIN) ||
			(a == `DFCW_IDX_SW) || (a == `DFCW_IDX_STATUS);
	end
endfunction

function [15:0] regRead;
	input [4:0] a;
	begin
		if (a[4:2] == `DFCW_GRP_DATA) begin
			regRead = {4'h0, dataArr[a[1:0]]};
		end else if (a[4:2] == `DFCW_GRP_GAIN) begin
			regRead = {4'h0, gainArr[a[1:0]]};
		end else if (a[4:2] == `DFCW_GRP_OFFS) begin
			regRead = {4'h0, offsArr[a[1:0]]};
		end else if (a[4:2] == `DFCW_GRP_CLR) begin
			regRead = {4'h0, clrArr[a[1:0]]};
		end else if (a[4:2] == `DFCW_GRP_CHCTL) begin
			regRead = {13'h0000, chCtlArr[a[1:0]]};
		end else if (a == `DFCW_IDX_MAIN) begin
			regRead = {12'h000, mainCtl_reg};
		end else if (a == `DFCW_IDX_STATUS) begin
			regRead = statusWord;
		end else begin
			regRead = 16'h0000;
		end
	end
endfunction

// ----------------------------------------
// serial receive and transmit
// ----------------------------------------
reg [31:0] rx_reg;
reg [5:0] bitCnt_reg;
reg [23:0] tx_reg;
reg [4:0] rbAddr_reg;
reg rbPend_reg;
reg packetErr_reg;

wire lenPlain = bitCnt_reg == `DFCW_LEN_PLAIN;
wire lenCheck = bitCnt_reg == `DFCW_LEN_CHECK;
wire [23:0] frameWord = lenCheck ? rx_reg[31:8] : rx_reg[23:0];
wire crcOk = crc8(rx_reg[31:8]) == rx_reg[7:0];
wire frameOk = selRise & (lenPlain | (lenCheck & crcOk));
wire crcFail = selRise & lenCheck & ~crcOk;
wire serWr = frameOk & ~frameWord[`DFCW_RD_BIT];
wire serRd = frameOk & frameWord[`DFCW_RD_BIT];
wire [4:0] frameAddr = frameWord[`DFCW_ADDR_HI:`DFCW_ADDR_LO];
wire echoOn = mainCtl_reg[`DFCW_MC_ECHO];
wire stLoadStatus = selFall & (echoOn | (rbPend_reg & (rbAddr_reg == `DFCW_IDX_STATUS)));

always @(posedge clk or posedge rst) begin
	if (rst) begin
		rx_reg <= 32'h00000000;
		bitCnt_reg <= 6'h00;
		tx_reg <= 24'h000000;
		serialDataOut <= 1'b0;
		rbAddr_reg <= 5'h00;
		rbPend_reg <= 1'b0;
	end else begin
		if (selFall) begin
			bitCnt_reg <= 6'h00;
			rbPend_reg <= 1'b0;
			if (echoOn) begin
				tx_reg <= {8'h00, statusWord};
				serialDataOut <= 1'b0;
			end else if (rbPend_reg) begin
				tx_reg <= {8'h00, regRead(rbAddr_reg)};
				serialDataOut <= 1'b0;
			end else begin
				tx_reg <= 24'h000000;
				serialDataOut <= 1'b0;
			end
		end else if (~selS) begin
			if (sclkFall) begin
				rx_reg <= {rx_reg[30:0], sdinS};
				if (bitCnt_reg != `DFCW_LEN_MAX) begin
					bitCnt_reg <= bitCnt_reg + 6'h01;
				end
			end
			if (sclkRise) begin
				serialDataOut <= tx_reg[23];
				tx_reg <= {tx_reg[22:0], 1'b0};
			end
		end
		if (serRd & ~echoOn) begin
			rbAddr_reg <= frameAddr;
			rbPend_reg <= 1'b1;
		end
	end
end

// ----------------------------------------
// apb slave, one wait state
// ----------------------------------------
wire apbIdx = paddr[1:0] == 2'h0 && paddr[7] == 1'b0;
wire [4:0] apbAddr = paddr[6:2];
// serial writes win the shared write port
wire apbGo = psel & penable & ~pready & ~serWr;
wire apbOk = apbIdx & regValid(apbAddr);
wire apbWr = apbGo & pwrite & apbOk & (apbAddr != `DFCW_IDX_STATUS);
wire wrEn = serWr | apbWr;
wire [4:0] wrAddr = serWr ? frameAddr : apbAddr;
wire [15:0] wrData = serWr ? frameWord[15:0] : pwdata[15:0];
wire apbStRead = apbGo & ~pwrite & apbIdx & (apbAddr == `DFCW_IDX_STATUS);

always @(posedge clk or posedge rst) begin
	if (rst) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else begin
		pready <= apbGo;
		pslverr <= apbGo & ~apbOk;
		if (apbGo & ~pwrite & apbOk) begin
			prdata <= {16'h0000, regRead(apbAddr)};
		end else begin
			prdata <= 32'h00000000;
		end
	end
end

// ----------------------------------------
// faults and status
// ----------------------------------------
// headroom flag from output stage
wire [3:0] ioutFault = headS;
// short sets vout bit; unipolar low output
wire [3:0] voutFault = shortS | (lowS & {4{uniS}});
always @* begin
	statusWord = 16'h0000;
	statusWord[3:0] = ioutFault;
	statusWord[7:4] = voutFault;
	statusWord[`DFCW_ST_OTEMP] = otS;
	statusWord[`DFCW_ST_PKT] = packetErr_reg;
	statusWord[`DFCW_ST_ALERT] = alertOut;
end

always @(posedge clk or posedge rst) begin
	if (rst) begin
		packetErr_reg <= 1'b0;
		faultOut <= 1'b0;
		faultOe <= 1'b0;
	end else begin
		// last bad word; read clears, set wins
		if (crcFail) begin
			packetErr_reg <= 1'b1;
		end else if (stLoadStatus | apbStRead) begin
			packetErr_reg <= 1'b0;
		end
		faultOut <= 1'b0;
		faultOe <= (|ioutFault) | (|voutFault) | otS | packetErr_reg | crcFail;
	end
end

// ----------------------------------------
// watchdog
// ----------------------------------------
reg [17:0] msCnt_reg;
reg [7:0] wdMs_reg;
reg [7:0] wdLimit;
wire msTick = msCnt_reg == MS_LAST;
wire wdEn = mainCtl_reg[`DFCW_MC_WDEN];
wire kick = wrEn & (wrAddr == `DFCW_IDX_SW) & (wrData == `DFCW_WD_KEY);

always @* begin
	case (mainCtl_reg[`DFCW_MC_WDSEL_HI:`DFCW_MC_WDSEL_LO])
		2'h0: wdLimit = `DFCW_WD_T0_MS;
		2'h1: wdLimit = `DFCW_WD_T1_MS;
		2'h2: wdLimit = `DFCW_WD_T2_MS;
		default: wdLimit = `DFCW_WD_T3_MS;
	endcase
end

always @(posedge clk or posedge rst) begin
	if (rst) begin
		msCnt_reg <= 18'h00000;
		wdMs_reg <= 8'h00;
		alertOut <= 1'b0;
	end else begin
		msCnt_reg <= msTick ? 18'h00000 : msCnt_reg + 18'h00001;
		if (~wdEn | kick) begin
			wdMs_reg <= 8'h00;
			alertOut <= 1'b0;
		end else if (msTick & ~alertOut) begin
			wdMs_reg <= wdMs_reg + 8'h01;
			if (wdMs_reg + 8'h01 >= wdLimit) begin
				alertOut <= 1'b1;
			end
		end
	end
end

// ----------------------------------------
// register file, calibration, clear
// ----------------------------------------
reg [3:0] pend_reg;
reg calValid_reg;
reg [1:0] calCh_reg;
reg [11:0] calRes_reg;
reg [1:0] selCh;
reg [24:0] prod;
reg [14:0] sum;
reg [11:0] calCode;
reg [3:0] clrHit;
integer i;

always @* begin
	selCh = 2'h0;
	for (i = 3; i >= 0; i = i - 1) begin
		if (pend_reg[i]) begin
			selCh = i[1:0];
		end
	end
	prod = dataArr[selCh] * ({1'b0, gainArr[selCh]} + 13'h0001);
	sum = {2'h0, prod[24:12]} + {3'h0, offsArr[selCh]};
	if (sum < `DFCW_MID_SCALE) begin
		calCode = 12'h000;
	end else if (sum - `DFCW_MID_SCALE > `DFCW_CODE_MAX) begin
		calCode = 12'hfff;
	end else begin
		calCode = sum[11:0] - 12'h800;
	end
	for (i = 0; i < 4; i = i + 1) begin
		clrHit[i] = clrRise & chCtlArr[i][`DFCW_CH_CLREN];
	end
end

always @(posedge clk or posedge rst) begin
	if (rst) begin
		for (i = 0; i < 4; i = i + 1) begin
			dataArr[i] <= 12'h000;
			gainArr[i] <= `DFCW_GAIN_RST;
			offsArr[i] <= `DFCW_OFFS_RST;
			clrArr[i] <= 12'h000;
			chCtlArr[i] <= 3'h0;
		end
		mainCtl_reg <= 4'h0;
		pend_reg <= 4'h0;
		calValid_reg <= 1'b0;
		calCh_reg <= 2'h0;
		calRes_reg <= 12'h000;
		dacCode <= 48'h000000000000;
		extRsetSel <= 4'h0;
		shortLimit8mA <= 4'h0;
	end else begin
		calValid_reg <= (|pend_reg) & ~clrHit[selCh];
		calCh_reg <= selCh;
		calRes_reg <= calCode;
		if (calValid_reg & ~clrHit[calCh_reg]) begin
			dacCode[calCh_reg*12 +: 12] <= calRes_reg;
		end
		pend_reg <= pend_reg & ~(pend_reg != 4'h0 ? (4'h1 << selCh) : 4'h0);
		if (wrEn) begin
			if (wrAddr[4:2] == `DFCW_GRP_DATA) begin
				dataArr[wrAddr[1:0]] <= wrData[11:0];
				pend_reg[wrAddr[1:0]] <= 1'b1;
			end else if (wrAddr[4:2] == `DFCW_GRP_GAIN) begin
				gainArr[wrAddr[1:0]] <= wrData[11:0];
			end else if (wrAddr[4:2] == `DFCW_GRP_OFFS) begin
				offsArr[wrAddr[1:0]] <= wrData[11:0];
			end else if (wrAddr[4:2] == `DFCW_GRP_CLR) begin
				clrArr[wrAddr[1:0]] <= wrData[11:0];
			end else if (wrAddr[4:2] == `DFCW_GRP_CHCTL) begin
				chCtlArr[wrAddr[1:0]] <= wrData[2:0];
			end else if (wrAddr == `DFCW_IDX_MAIN) begin
				// echo resets off, host toggles it
				mainCtl_reg <= wrData[3:0];
			end
		end
		// clear code; others untouched; held till write
		for (i = 0; i < 4; i = i + 1) begin
			if (clrHit[i]) begin
				dacCode[i*12 +: 12] <= clrArr[i];
				pend_reg[i] <= 1'b0;
			end
			extRsetSel[i] <= chCtlArr[i][`DFCW_CH_EXTR];
			shortLimit8mA[i] <= chCtlArr[i][`DFCW_CH_LIM8];
		end
	end
end

endmodule // dfcw_core

`default_nettype wire

// ### verilog/dfcw_defines.vh
/*
 * constants for the dac fault, calibration, packet check and watchdog block.
 * assumes: included by bare name from verilog/ sources, 200 MHz clk.
 */
`ifndef DFCW_DEFINES_VH
`define DFCW_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define DFCW_CLK_MHZ 200
`define DFCW_WD_T0_MS 8'd5
`define DFCW_WD_T1_MS 8'd10
`define DFCW_WD_T2_MS 8'd100
`define DFCW_WD_T3_MS 8'd200
`define DFCW_WD_KEY 16'h0195

// ----------------------------------------
// serial frame
// ----------------------------------------
`define DFCW_LEN_PLAIN 6'h18
`define DFCW_LEN_CHECK 6'h20
`define DFCW_LEN_MAX 6'h21
`define DFCW_CRC_POLY 8'h07
`define DFCW_RD_BIT 23
`define DFCW_ADDR_HI 20
`define DFCW_ADDR_LO 16

// ----------------------------------------
// register indices and groups
// ----------------------------------------
`define DFCW_GRP_DATA 3'h0
`define DFCW_GRP_GAIN 3'h1
`define DFCW_GRP_OFFS 3'h2
`define DFCW_GRP_CLR 3'h3
`define DFCW_GRP_CHCTL 3'h4
`define DFCW_IDX_MAIN 5'h14
`define DFCW_IDX_SW 5'h15
`define DFCW_IDX_STATUS 5'h16

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DFCW_GAIN_RST 12'hfff
`define DFCW_OFFS_RST 12'h800
`define DFCW_MID_SCALE 15'h0800
`define DFCW_CODE_MAX 15'h0fff
`define DFCW_CH_CLREN 0
`define DFCW_CH_EXTR 1
`define DFCW_CH_LIM8 2
`define DFCW_MC_ECHO 0
`define DFCW_MC_WDEN 1
`define DFCW_MC_WDSEL_HI 3
`define DFCW_MC_WDSEL_LO 2
`define DFCW_ST_OTEMP 8
`define DFCW_ST_PKT 9
`define DFCW_ST_ALERT 10

`endif

// ### verilog/dfcw_sync.v
/*
 * two-flop synchroniser for a group of asynchronous pins.
 * assumes: inputs come from outside the clk domain.
 */
`default_nettype none

module dfcw_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

reg [W-1:0] meta_reg;

// only q reads the first stage
always @(posedge clk or posedge rst) begin
	if (rst) begin
		meta_reg <= {W{1'b0}};
		q <= {W{1'b0}};
	end else begin
		meta_reg <= d;
		q <= meta_reg;
	end
end

endmodule // dfcw_sync

`default_nettype wire

// ### test/dfcw_core_properties.sv
/* port checker for dfcw_core.
   assumes: bound onto dfcw_core, one clk domain. */
`default_nettype none
module dfcw_core_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic [3:0] headroomLow,
	input wire logic [3:0] voutShort,
	input wire logic overTemp,
	input wire logic faultOut,
	input wire logic faultOe,
	input wire logic alertOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----------------
	// properties
	// ----------------
	// bound covers sync plus output flop
	sequence sFaultSoon;
		##[1:6] faultOe;
	endsequence
	sequence sAnswer;
		##[0:3] pready ##1 !pready;
	endsequence
	chk_fault_drain: assert property (faultOut == 1'b0)
		else $error("fault data driven high");
	chk_headroom_fault: assert property ($rose(|headroomLow) |-> sFaultSoon)
		else $error("headroom flag missed");
	chk_short_fault: assert property ($rose(|voutShort) |-> sFaultSoon)
		else $error("short flag missed");
	chk_temp_fault: assert property ($rose(overTemp) |-> sFaultSoon)
		else $error("overtemp flag missed");
	chk_apb_answer: assert property (psel && penable && !pready |-> sAnswer)
		else $error("apb answer late or long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	chk_reset_quiet: assert property ($past(rst) |-> !faultOe && !alertOut)
		else $error("outputs active after reset");
endmodule // dfcw_core_properties
`default_nettype wire

// ### test/dfcw_host.sv
/* host model driving the serial link.
   assumes: 48 ns link clock, still between frames. */
`default_nettype none
module dfcw_host (
	output var logic serialClk,
	output var logic frameSelN,
	output var logic serialDataIn,
	input wire logic serialDataOut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rxWord;
	initial begin
		serialClk = 1'b0;
		frameSelN = 1'b1;
		serialDataIn = 1'b1;
		rxWord = 32'h0;
	end
	function automatic logic [7:0] crc8(input logic [23:0] w);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic shiftOut(input logic [31:0] w, input int n);
		frameSelN = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#12 serialDataIn = w[i];
			#12 serialClk = 1'b1;
			#24 serialClk = 1'b0;
			rxWord = {rxWord[30:0], serialDataOut};
		end
		#24 frameSelN = 1'b1;
		// released line shows no stale value
		serialDataIn = ~serialDataIn;
		#100;
	endtask
	task automatic send24(input logic [23:0] w);
		shiftOut({8'h00, w}, 24);
	endtask
	task automatic send32(input logic [23:0] w, input logic [7:0] flip);
		shiftOut({w, crc8(w) ^ flip}, 32);
	endtask
endmodule // dfcw_host
`default_nettype wire

// ### test/dfcw_core_tb.sv
/* self-checking bench for dfcw_core.
   assumes: dfcw_host on the link, apb master here. */
`default_nettype none
module dfcw_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic clearIn = 1'b0;
	logic unipolarMode = 1'b0;
	logic overTemp = 1'b0;
	logic [3:0] headroomLow = 4'h0;
	logic [3:0] voutShort = 4'h0;
	logic [3:0] voutLow = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, serialDataOut, faultOut, faultOe, alertOut;
	logic serialClk, frameSelN, serialDataIn;
	logic [47:0] dacCode;
	logic [3:0] extRsetSel, shortLimit8mA;
	logic [31:0] rd;
	logic err;
	int miscompares = 0;
	int compares = 0;
	int wdPeriodMs[4] = '{5, 10, 100, 200};
	always #2.5 clk = ~clk;
	dfcw_core #(.MS_CYCLES(32'd20)) dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serialClk(serialClk), .frameSelN(frameSelN),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .clearIn(clearIn),
		.headroomLow(headroomLow), .voutShort(voutShort), .voutLow(voutLow),
		.unipolarMode(unipolarMode), .overTemp(overTemp), .faultOut(faultOut),
		.faultOe(faultOe), .alertOut(alertOut), .dacCode(dacCode),
		.extRsetSel(extRsetSel), .shortLimit8mA(shortLimit8mA));
	dfcw_host host (.serialClk(serialClk), .frameSelN(frameSelN),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut));
	// ----------------
	// tasks
	// ----------------
	task automatic stop_test;
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// values taken when the task is called, compared after the next edge
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		@(posedge clk);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		// a stuck slave is ended by the bench watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		check({16'h0, rd}, {16'h0, e});
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		#100us;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdchk(8'h10, 32'h0fff);
		rdchk(8'h20, 32'h0800);
		rdchk(8'h50, 32'h0000);
		apb(8'h80, 1'b1, 32'h1);
		check({47'h0, err}, 48'h1);
		apb(8'h10, 1'b1, 32'h07ff);
		repeat (4) @(posedge clk);
		check(dacCode, 48'h0);
		apb(8'h00, 1'b1, 32'h0400);
		apb(8'h40, 1'b1, 32'h1);
		apb(8'h30, 1'b1, 32'h0123);
		apb(8'h04, 1'b1, 32'h0fff);
		apb(8'h4c, 1'b1, 32'h6);
		repeat (4) @(posedge clk);
		check(dacCode, 48'h000000fff200);
		check({40'h0, extRsetSel, shortLimit8mA}, 48'h88);
		clearIn <= 1'b1;
		repeat (8) @(posedge clk);
		check(dacCode, 48'h000000fff123);
		clearIn <= 1'b0;
		repeat (8) @(posedge clk);
		check(dacCode, 48'h000000fff123);
		host.send24(24'h020800);
		check(dacCode, 48'h000800fff123);
		host.send32(24'h020100, 8'h00);
		check(dacCode, 48'h000100fff123);
		host.send32(24'h020aaa, 8'h01);
		check(dacCode, 48'h000100fff123);
		check({47'h0, faultOe}, 48'h1);
		rdchk(8'h58, 32'h0200);
		check({47'h0, faultOe}, 48'h0);
		rdchk(8'h58, 32'h0000);
		for (int s = 0; s < 4; s++) begin
			apb(8'h50, 1'b1, {28'h0, s[1:0], 2'b10});
			apb(8'h54, 1'b1, 32'h0195);
			repeat (20 * wdPeriodMs[s] - 20) @(posedge clk);
			check({47'h0, alertOut}, 48'h0);
			repeat (40) @(posedge clk);
			check({47'h0, alertOut}, 48'h1);
		end
		apb(8'h54, 1'b1, 32'h0195);
		check({47'h0, alertOut}, 48'h0);
		apb(8'h50, 1'b1, 32'h0);
		headroomLow <= 4'h4;
		voutShort <= 4'h2;
		voutLow <= 4'h1;
		unipolarMode <= 1'b1;
		overTemp <= 1'b1;
		repeat (8) @(posedge clk);
		check({47'h0, faultOe}, 48'h1);
		rdchk(8'h58, 32'h0134);
		apb(8'h50, 1'b1, 32'h1);
		host.send24(24'h030000);
		check({24'h0, host.rxWord[23:0]}, 48'h000134);
		apb(8'h50, 1'b1, 32'h0);
		host.send24(24'h810000);
		host.send24(24'h000000);
		check({24'h0, host.rxWord[23:0]}, 48'h000fff);
		stop_test();
	end
endmodule // dfcw_core_tb
bind dfcw_core dfcw_core_properties chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.headroomLow(headroomLow), .voutShort(voutShort), .overTemp(overTemp),
	.faultOut(faultOut), .faultOe(faultOe), .alertOut(alertOut));
`default_nettype wire
